// File: rtl/encoder_input_defines.vh
`ifndef ENCODER_INPUT_DEFINES_VH
`define ENCODER_INPUT_DEFINES_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define ADDR_DIRECTION 8'h00
`define ADDR_LINE_COUNT 8'h04
`define ADDR_ASSIGN 8'h08
`define ADDR_ORIENT 8'h0c
`define ADDR_MOTOR2 8'h10
`define ADDR_LOSS_EN 8'h14
`define ADDR_INFUNC 8'h18
`define ADDR_STATUS 8'h1c
`define ADDR_IRQ_STAT 8'h20
`define ADDR_IRQ_MASK 8'h24
`define ADDR_POSITION 8'h28

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define DIR_RESET 7'h01
`define DIR_CW_LOW 7'h00
`define DIR_CCW_LOW 7'h01
`define DIR_CW_HIGH 7'h64
`define DIR_CCW_HIGH 7'h65
`define LINES_RESET 13'h0400
`define LINES_MAX 13'h1000
`define ASSIGN_RESET 1'b0
`define ORIENT_MACHINE_LO 5'h0a
`define ORIENT_MACHINE_HI 5'h0c
`define MOTOR2_NONE 14'h270f
`define INFUNC_MOTOR_SET 8'h03
`define FREQ_LIMIT_HZ 16'h0078

// ----------------------------------------------------------------
// status and interrupt bits
// ----------------------------------------------------------------
`define ST_MACHINE_END 0
`define ST_SECOND_MOTOR 1
`define ST_THIS_CARD 2
`define ST_FREQ_WARN 3
`define ST_LOSS 4
`define IRQ_INDEX 0
`define IRQ_LOSS 1
`define IRQ_WARN 2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ 25000000
`define LOSS_TIME_MS 10
`define LOSS_CYCLES (`CLK_HZ / 1000 * `LOSS_TIME_MS)

`endif

// File: rtl/quad_decoder.v
`timescale 1ns/1ps
`include "encoder_input_defines.vh"

module quad_decoder (
	input wire sys_clk,
	input wire sys_rst,
	input wire phase_a,
	input wire phase_b,
	input wire phase_z,
	input wire invert,
	output reg [31:0] position_reg,
	output reg index_pulse_reg,
	output reg step_pulse_reg
);
	reg a_q_reg;
	reg b_q_reg;
	reg z_q_reg;
	reg fwd;
	reg moved;

	// ----------------------------------------------------------------
	// x4 decode: each edge on either channel is one count
	// ----------------------------------------------------------------
	always @* begin
		moved = (phase_a ^ a_q_reg) ^ (phase_b ^ b_q_reg);
		fwd = phase_a ^ b_q_reg;
	end

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			// track the pins through reset so a high level at release is not an edge
			a_q_reg <= phase_a;
			b_q_reg <= phase_b;
			z_q_reg <= phase_z;
			position_reg <= 32'h0000_0000;
			index_pulse_reg <= 1'b0;
			step_pulse_reg <= 1'b0;
		end else begin
			a_q_reg <= phase_a;
			b_q_reg <= phase_b;
			z_q_reg <= phase_z;
			index_pulse_reg <= phase_z & ~z_q_reg;
			step_pulse_reg <= moved;
			// a double edge in one cycle is illegal quadrature and is dropped
			if (moved) begin
				if (fwd ^ invert) begin
					position_reg <= position_reg + 32'h0000_0001;
				end else begin
					position_reg <= position_reg - 32'h0000_0001;
				end
			end
		end
	end
endmodule // quad_decoder

// File: rtl/encoder_input_setup.v
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "encoder_input_defines.vh"

module encoder_input_setup #(
	parameter LOSS_CYCLES = `LOSS_CYCLES
) (
	input wire sys_clk,
	input wire sys_rst,
	input wire haddr_sel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire phase_a,
	input wire phase_b,
	input wire phase_z,
	input wire terminal_in,
	input wire [15:0] output_freq_hz,
	output reg [31:0] orient_position,
	output reg [31:0] feedback_position,
	output reg [31:0] vector_position,
	output reg this_card_active,
	output reg second_motor_active,
	output reg machine_end_orient,
	output reg freq_warning,
	output reg encoder_loss_fault,
	output reg irq
);
	// ----------------------------------------------------------------
	// settings
	// ----------------------------------------------------------------
	reg [6:0] encoder_direction_setting_reg;
	reg [12:0] encoder_line_count_setting_reg;
	reg option_slot_assignment_reg;
	reg [4:0] orientation_mode_select_reg;
	reg [13:0] second_motor_type_setting_reg;
	reg signal_loss_detect_enable_reg;
	reg [7:0] input_function_select_first_reg;
	reg [2:0] irq_stat_reg;
	reg [2:0] irq_mask_reg;

	// ----------------------------------------------------------------
	// bus state
	// ----------------------------------------------------------------
	reg wr_pend_reg;
	reg [7:0] wr_addr_reg;
	reg [31:0] rd_data_next;
	reg [2:0] irq_stat_next;
	reg we_direction;
	reg we_line_count;
	reg we_assign;
	reg we_orient;
	reg we_motor2;
	reg we_loss_en;
	reg we_infunc;
	reg we_irq_mask;
	reg dir_legal;
	reg lines_legal;

	// ----------------------------------------------------------------
	// decode and loss watch
	// ----------------------------------------------------------------
	wire [31:0] position;
	wire index_pulse;
	wire step_pulse;
	reg [31:0] loss_cnt_reg;
	reg loss_reg;
	reg invert;
	reg high_variant;
	reg motor_set_select_input;
	reg second_sel;
	reg machine_end;
	reg warn;
	reg loss_event;
	wire addr_phase;
	wire [7:0] a8;

	assign addr_phase = haddr_sel & htrans[1] & hready;
	assign a8 = haddr[7:0];

	// ----------------------------------------------------------------
	// setting interpretation
	// ----------------------------------------------------------------
	always @* begin
		// odd codes are counterclockwise forward; the decoder counts clockwise as up
		invert = encoder_direction_setting_reg[0];
		high_variant = (encoder_direction_setting_reg == `DIR_CW_HIGH) ||
			(encoder_direction_setting_reg == `DIR_CCW_HIGH);
		warn = ~high_variant && (output_freq_hz > `FREQ_LIMIT_HZ);
		motor_set_select_input = terminal_in &&
			(input_function_select_first_reg == `INFUNC_MOTOR_SET);
		second_sel = motor_set_select_input &&
			(second_motor_type_setting_reg != `MOTOR2_NONE);
		machine_end = option_slot_assignment_reg &&
			(orientation_mode_select_reg >= `ORIENT_MACHINE_LO) &&
			(orientation_mode_select_reg <= `ORIENT_MACHINE_HI);
		// loss watch only runs while a line count is set; lines stay local to this card
		loss_event = signal_loss_detect_enable_reg && (encoder_line_count_setting_reg != 13'h0000) &&
			(loss_cnt_reg == LOSS_CYCLES - 1) && ~loss_reg;
	end

	quad_decoder u_decoder (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.phase_a(phase_a),
		.phase_b(phase_b),
		.phase_z(phase_z),
		.invert(invert),
		.position_reg(position),
		.index_pulse_reg(index_pulse),
		.step_pulse_reg(step_pulse)
	);

	// ----------------------------------------------------------------
	// bus read mux
	// ----------------------------------------------------------------
	always @* begin
		case (a8)
		`ADDR_DIRECTION: rd_data_next = {25'h0, encoder_direction_setting_reg};
		`ADDR_LINE_COUNT: rd_data_next = {19'h0, encoder_line_count_setting_reg};
		`ADDR_ASSIGN: rd_data_next = {31'h0, option_slot_assignment_reg};
		`ADDR_ORIENT: rd_data_next = {27'h0, orientation_mode_select_reg};
		`ADDR_MOTOR2: rd_data_next = {18'h0, second_motor_type_setting_reg};
		`ADDR_LOSS_EN: rd_data_next = {31'h0, signal_loss_detect_enable_reg};
		`ADDR_INFUNC: rd_data_next = {24'h0, input_function_select_first_reg};
		`ADDR_STATUS: rd_data_next = {27'h0, loss_reg, warn, ~(option_slot_assignment_reg ^ second_sel),
			second_sel, machine_end};
		`ADDR_IRQ_STAT: rd_data_next = {29'h0, irq_stat_reg};
		`ADDR_IRQ_MASK: rd_data_next = {29'h0, irq_mask_reg};
		`ADDR_POSITION: rd_data_next = position;
		default: rd_data_next = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// interrupt status: set wins over write-one clear
	// ----------------------------------------------------------------
	always @* begin
		irq_stat_next = irq_stat_reg;
		if (wr_pend_reg && wr_addr_reg == `ADDR_IRQ_STAT) begin
			irq_stat_next = irq_stat_next & ~hwdata[2:0];
		end
		if (index_pulse) begin
			irq_stat_next[`IRQ_INDEX] = 1'b1;
		end
		if (loss_event) begin
			irq_stat_next[`IRQ_LOSS] = 1'b1;
		end
		if (warn && ~freq_warning) begin
			irq_stat_next[`IRQ_WARN] = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// write strobes, valid in the data phase
	// ----------------------------------------------------------------
	always @* begin
		we_direction = wr_pend_reg && (wr_addr_reg == `ADDR_DIRECTION);
		we_line_count = wr_pend_reg && (wr_addr_reg == `ADDR_LINE_COUNT);
		we_assign = wr_pend_reg && (wr_addr_reg == `ADDR_ASSIGN);
		we_orient = wr_pend_reg && (wr_addr_reg == `ADDR_ORIENT);
		we_motor2 = wr_pend_reg && (wr_addr_reg == `ADDR_MOTOR2);
		we_loss_en = wr_pend_reg && (wr_addr_reg == `ADDR_LOSS_EN);
		we_infunc = wr_pend_reg && (wr_addr_reg == `ADDR_INFUNC);
		we_irq_mask = wr_pend_reg && (wr_addr_reg == `ADDR_IRQ_MASK);
		// only the four legal direction codes are taken; anything else keeps the old sense
		dir_legal = (hwdata[6:0] == `DIR_CW_LOW) || (hwdata[6:0] == `DIR_CCW_LOW) ||
			(hwdata[6:0] == `DIR_CW_HIGH) || (hwdata[6:0] == `DIR_CCW_HIGH);
		lines_legal = (hwdata[31:13] == 19'h0) && (hwdata[12:0] <= `LINES_MAX);
	end

	// ----------------------------------------------------------------
	// settings: each holds its value until a legal write
	// ----------------------------------------------------------------
	// a refused value is dropped without a response; software reads back to see it
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			encoder_direction_setting_reg <= `DIR_RESET;
		end else if (we_direction && dir_legal) begin
			encoder_direction_setting_reg <= hwdata[6:0];
		end
	end

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			encoder_line_count_setting_reg <= `LINES_RESET;
		end else if (we_line_count && lines_legal) begin
			encoder_line_count_setting_reg <= hwdata[12:0];
		end
	end

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			option_slot_assignment_reg <= `ASSIGN_RESET;
		end else if (we_assign) begin
			option_slot_assignment_reg <= hwdata[0];
		end
	end

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			orientation_mode_select_reg <= 5'h00;
		end else if (we_orient) begin
			orientation_mode_select_reg <= hwdata[4:0];
		end
	end

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			second_motor_type_setting_reg <= `MOTOR2_NONE;
		end else if (we_motor2) begin
			second_motor_type_setting_reg <= hwdata[13:0];
		end
	end

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			signal_loss_detect_enable_reg <= 1'b0;
		end else if (we_loss_en) begin
			signal_loss_detect_enable_reg <= hwdata[0];
		end
	end

	// the terminal is only a motor-set select while its function code says so
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			input_function_select_first_reg <= 8'h00;
		end else if (we_infunc) begin
			input_function_select_first_reg <= hwdata[7:0];
		end
	end

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			irq_mask_reg <= 3'h0;
		end else if (we_irq_mask) begin
			irq_mask_reg <= hwdata[2:0];
		end
	end

	// ----------------------------------------------------------------
	// bus slave: no wait states, read data loaded in the address phase
	// ----------------------------------------------------------------
	// a position read returns the same count the position outputs carry in the data phase
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_reg <= addr_phase & hwrite;
			if (addr_phase) begin
				wr_addr_reg <= a8;
				if (~hwrite) begin
					hrdata <= rd_data_next;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// interrupt status and loss timer
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			irq_stat_reg <= 3'h0;
			loss_cnt_reg <= 32'h0000_0000;
			loss_reg <= 1'b0;
		end else begin
			irq_stat_reg <= irq_stat_next;
			// loss: no quadrature edge for the timeout while enabled
			// the timer saturates so a stalled shaft raises one event, not a train of them
			if (step_pulse || ~signal_loss_detect_enable_reg) begin
				loss_cnt_reg <= 32'h0000_0000;
				loss_reg <= 1'b0;
			end else if (loss_cnt_reg != LOSS_CYCLES - 1) begin
				loss_cnt_reg <= loss_cnt_reg + 32'h0000_0001;
			end else if (loss_event) begin
				loss_reg <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from flops
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			irq <= 1'b0;
			orient_position <= 32'h0000_0000;
			feedback_position <= 32'h0000_0000;
			vector_position <= 32'h0000_0000;
			this_card_active <= 1'b1;
			second_motor_active <= 1'b0;
			machine_end_orient <= 1'b0;
			freq_warning <= 1'b0;
			encoder_loss_fault <= 1'b0;
		end else begin
			irq <= |(irq_stat_next & irq_mask_reg);
			// one shared count feeds all three consumers; separate flops ease routing to each
			orient_position <= position;
			feedback_position <= position;
			vector_position <= position;
			second_motor_active <= second_sel;
			// card serves first motor at 0, second at 1; machine end makes it the machine-end card
			this_card_active <= machine_end | (option_slot_assignment_reg ^ second_sel) ^ 1'b1;
			machine_end_orient <= machine_end;
			freq_warning <= warn;
			encoder_loss_fault <= loss_reg;
		end
	end
endmodule // encoder_input_setup

// File: sim/quad_encoder_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// rigid one-to-one encoder, one state per command
// ----------------------------------------
module quad_encoder_model (
	input wire sys_clk,
	input wire fwd,
	input wire rev,
	input wire index,
	output wire phase_a,
	output wire phase_b,
	output reg phase_z
);
	reg [1:0] ph_reg = 2'h0;
	initial phase_z = 1'b0;
	always @(posedge sys_clk) begin
		if (fwd) ph_reg <= ph_reg + 2'h1;
		else if (rev) ph_reg <= ph_reg - 2'h1;
		phase_z <= index;
	end
	// a leads b by a quarter period when stepping forward
	assign phase_a = ph_reg[1] ^ ph_reg[0];
	assign phase_b = ph_reg[1];
endmodule // quad_encoder_model

// File: sim/encoder_input_setup_sva.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module encoder_input_setup_sva #(
	parameter LOSS_CYCLES = 20
) (
	input wire sys_clk,
	input wire sys_rst,
	input wire phase_a,
	input wire phase_b,
	input wire terminal_in,
	input wire [15:0] output_freq_hz,
	input wire hreadyout,
	input wire hresp,
	input wire [31:0] orient_position,
	input wire [31:0] feedback_position,
	input wire [31:0] vector_position,
	input wire this_card_active,
	input wire second_motor_active,
	input wire machine_end_orient,
	input wire freq_warning,
	input wire encoder_loss_fault
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	reg a_q, b_q;
	reg [31:0] idle_reg;
	wire moved = (phase_a != a_q) || (phase_b != b_q);
	// idle time of the link, the loss timer must not beat it
	always @(posedge sys_clk) begin
		a_q <= phase_a;
		b_q <= phase_b;
		idle_reg <= (sys_rst || moved) ? 32'h0 : idle_reg + 32'h1;
	end
	AST_BUS_OKAY: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
	AST_SHARED: assert property (orient_position == feedback_position && feedback_position == vector_position)
		else $error("positions differ");
	AST_STEP: assert property (!$stable(feedback_position) |->
		((feedback_position - $past(feedback_position)) inside {32'h1, 32'hffffffff})
		&& ($past(phase_a, 2) != $past(phase_a, 3) || $past(phase_b, 2) != $past(phase_b, 3)))
		else $error("position moved without one edge");
	AST_WARN: assert property (freq_warning |-> $past(output_freq_hz) > 16'h0078) else $error("warning at low freq");
	AST_SECOND: assert property (second_motor_active |-> $past(terminal_in)) else $error("second motor without input");
	AST_MACHINE: assert property (machine_end_orient |-> this_card_active) else $error("machine end off card");
	AST_LOSS_SET: assert property ($rose(encoder_loss_fault) |-> idle_reg >= LOSS_CYCLES - 2)
		else $error("loss flagged early");
	AST_LOSS_CLR: assert property (encoder_loss_fault && moved |-> ##[1:3] !encoder_loss_fault)
		else $error("loss kept after edge");
endmodule // encoder_input_setup_sva

bind encoder_input_setup encoder_input_setup_sva #(.LOSS_CYCLES(LOSS_CYCLES)) encoder_input_setup_sva_inst (
	.sys_clk, .sys_rst, .phase_a, .phase_b, .terminal_in, .output_freq_hz, .hreadyout, .hresp,
	.orient_position, .feedback_position, .vector_position, .this_card_active, .second_motor_active,
	.machine_end_orient, .freq_warning, .encoder_loss_fault
);

// File: sim/encoder_input_setup_tb.sv
`timescale 1ns/1ps
`include "encoder_input_defines.vh"
module encoder_input_setup_tb;
	reg sys_clk = 0, sys_rst = 1, haddr_sel = 0, hwrite = 0, fwd = 0, rev = 0, index = 0, terminal_in = 0;
	reg [31:0] haddr = 0, hwdata = 0, rdata = 0, pos_exp = 0;
	reg [1:0] htrans = 0;
	reg [2:0] hsize = 3'h2;
	reg [15:0] output_freq_hz = 0;
	wire [31:0] hrdata, orient_position, feedback_position, vector_position;
	wire hready, hreadyout, hresp, phase_a, phase_b, phase_z, this_card_active, second_motor_active;
	wire machine_end_orient, freq_warning, encoder_loss_fault, irq;
	integer failures = 0, compares = 0, i, j;
	always #20 sys_clk = ~sys_clk;
	assign hready = hreadyout;
	encoder_input_setup #(.LOSS_CYCLES(20)) encoder_input_setup_inst (.sys_clk, .sys_rst, .haddr_sel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .phase_a, .phase_b, .phase_z, .terminal_in,
		.output_freq_hz, .orient_position, .feedback_position, .vector_position, .this_card_active,
		.second_motor_active, .machine_end_orient, .freq_warning, .encoder_loss_fault, .irq);
	quad_encoder_model quad_encoder_model_inst (.sys_clk, .fwd, .rev, .index, .phase_a, .phase_b, .phase_z);
	// ----------------------------------------
	// bus cycles and checks
	// ----------------------------------------
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task xfer(input w, input [7:0] a, input [31:0] d);
		begin
			haddr_sel <= 1;
			haddr <= {24'h0, a};
			htrans <= 2'h2;
			hwrite <= w;
			@(posedge sys_clk);
			while (hreadyout !== 1'b1) @(posedge sys_clk);
			htrans <= 2'h0;
			haddr_sel <= 0;
			hwdata <= d;
			@(posedge sys_clk);
			while (hreadyout !== 1'b1) @(posedge sys_clk);
			rdata = hrdata;
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		xfer(1, a, d);
	endtask
	task rchk(input [7:0] a, input [31:0] e);
		begin
			xfer(0, a, 0);
			chk(rdata, e);
		end
	endtask
	task wt(input integer n);
		repeat (n) @(posedge sys_clk);
	endtask
	// steps are spaced so the decoder sees every edge on its own
	task step(input f);
		begin
			fwd <= f;
			rev <= !f;
			@(posedge sys_clk);
			fwd <= 0;
			rev <= 0;
			wt(3);
		end
	endtask
	task final_report;
		begin
			$display("failures=%0d compares=%0d", failures, compares);
			if (failures == 0 && compares > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	initial begin
		repeat (4000) @(posedge sys_clk);
		failures = failures + 1;
		final_report;
	end
	initial begin
		wt(3);
		sys_rst <= 0;
		wt(1);
		rchk(`ADDR_DIRECTION, 32'h1);
		rchk(`ADDR_LINE_COUNT, 32'h400);
		rchk(`ADDR_ASSIGN, 32'h0);
		rchk(`ADDR_MOTOR2, 32'h270f);
		rchk(8'h40, 32'h0);
		for (i = 0; i < 4; i = i + 1) begin
			wr(`ADDR_DIRECTION, (i[1] ? 32'h64 : 32'h0) + i[0]);
			wr(`ADDR_DIRECTION, 32'h2);
			rchk(`ADDR_DIRECTION, (i[1] ? 32'h64 : 32'h0) + i[0]);
			wr(`ADDR_ASSIGN, i[1]);
			for (j = 0; j < 4; j = j + 1) begin
				step(j != 3);
				pos_exp = pos_exp + (((j != 3) ^ i[0]) ? 32'h1 : 32'hffffffff);
			end
			chk(feedback_position, pos_exp);
			chk(orient_position, pos_exp);
			chk(vector_position, pos_exp);
			rchk(`ADDR_POSITION, pos_exp);
		end
		wr(`ADDR_LINE_COUNT, 32'h1000);
		wr(`ADDR_LINE_COUNT, 32'h1001);
		rchk(`ADDR_LINE_COUNT, 32'h1000);
		wr(`ADDR_ASSIGN, 0);
		wr(`ADDR_DIRECTION, 0);
		output_freq_hz <= 16'd121;
		wt(3);
		chk(freq_warning, 1);
		chk(irq, 0);
		wr(`ADDR_IRQ_MASK, 32'h4);
		wt(2);
		chk(irq, 1);
		wr(`ADDR_IRQ_STAT, 32'h4);
		wt(2);
		chk(irq, 0);
		output_freq_hz <= 16'd120;
		wt(3);
		chk(freq_warning, 0);
		wr(`ADDR_DIRECTION, 32'h64);
		output_freq_hz <= 16'd200;
		wt(3);
		chk(freq_warning, 0);
		wr(`ADDR_MOTOR2, 0);
		terminal_in <= 1;
		wt(3);
		chk(second_motor_active, 0);
		wr(`ADDR_INFUNC, `INFUNC_MOTOR_SET);
		wt(3);
		chk(second_motor_active, 1);
		rchk(`ADDR_STATUS, 32'h2);
		chk(this_card_active, 0);
		wr(`ADDR_ASSIGN, 1);
		wt(3);
		chk(this_card_active, 1);
		wr(`ADDR_MOTOR2, 32'h270f);
		wt(3);
		chk(second_motor_active, 0);
		chk(this_card_active, 0);
		for (i = 9; i < 14; i = i + 1) begin
			wr(`ADDR_ORIENT, i);
			wt(3);
			chk(machine_end_orient, i >= 10 && i <= 12);
		end
		wr(`ADDR_ORIENT, 32'ha);
		wr(`ADDR_ASSIGN, 0);
		wt(3);
		chk(machine_end_orient, 0);
		wr(`ADDR_IRQ_MASK, 32'h3);
		wr(`ADDR_IRQ_STAT, 32'h7);
		wr(`ADDR_LOSS_EN, 1);
		wt(30);
		chk(encoder_loss_fault, 1);
		chk(irq, 1);
		rchk(`ADDR_STATUS, 32'h14);
		step(1);
		wt(1);
		chk(encoder_loss_fault, 0);
		wr(`ADDR_LOSS_EN, 0);
		rchk(`ADDR_IRQ_STAT, 32'h2);
		wr(`ADDR_IRQ_STAT, 32'h2);
		index <= 1;
		wt(1);
		index <= 0;
		wt(3);
		rchk(`ADDR_IRQ_STAT, 32'h1);
		wr(`ADDR_IRQ_STAT, 32'h1);
		wt(2);
		chk(irq, 0);
		final_report;
	end
endmodule // encoder_input_setup_tb
